// ===== rtl/tqsl_top.sv
// Torque-mode speed limiter with speed/position loop parameter sets.
// Assumes a 200 MHz clock; preset-select inputs arrive from pins.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps

module tqsl_top #(
  parameter int UPDATE_CYCLES = tqsl_pkg::TQSL_UPDATE_CYCLES
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic [tqsl_pkg::TQSL_AW-1:0] reg_addr_i,
  input  wire logic [tqsl_pkg::TQSL_DW-1:0] reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [tqsl_pkg::TQSL_DW-1:0] reg_rdata_o,
  input  wire logic                        preset_speed_sel_bit0_i,
  input  wire logic                        preset_speed_sel_bit1_i,
  input  wire logic                        preset_speed_sel_bit2_i,
  input  wire logic signed [15:0]          analog_speed_cmd_i,
  input  wire logic signed [15:0]          motor_speed_i,
  input  wire logic                        gain_set_sel_i,
  output logic [15:0]                      effective_ceiling_o,
  output logic                             overspeed_o,
  output logic [15:0]                      torque_scale_o,
  output tqsl_pkg::tqsl_gain_set_s         active_gains_o,
  output logic [15:0]                      inertia_ratio_o,
  output logic [15:0]                      pdff_coef_o,
  output tqsl_pkg::tqsl_ctrl_e             ctrl_structure_o
);
  import tqsl_pkg::*;

  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    if (v[15]) begin
      mag16 = (v == 16'sh8000) ? 16'h7FFF : 16'(-v);
    end else begin
      mag16 = v;
    end
  endfunction

  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v < lo) begin
      clamp16 = lo;
    end else if (v > hi) begin
      clamp16 = hi;
    end else begin
      clamp16 = v;
    end
  endfunction

  // Reset release
  logic rst_meta;
  logic rst_sync_n;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Pin synchronisers for the preset-select inputs and gain select
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {gain_set_sel_i, preset_speed_sel_bit2_i,
                   preset_speed_sel_bit1_i, preset_speed_sel_bit0_i};
      pin_sync <= pin_meta;
    end
  end

  logic [2:0] preset_idx;
  assign preset_idx = pin_sync[2:0];

  // Parameter registers
  logic [1:0]  limit_source_select;
  logic [15:0] basic_speed_ceiling;
  logic [15:0] overspeed_feedback_margin;
  logic [15:0] system_max_speed;
  logic [15:0] speed_gain_set_a;
  logic [15:0] speed_gain_set_b;
  logic [15:0] speed_integ_time_set_a;
  logic [15:0] speed_integ_time_set_b;
  logic [15:0] position_gain_set_a;
  logic [15:0] position_gain_set_b;
  logic [15:0] inertia_ratio;
  logic [15:0] speed_ctrl_structure_coef;
  logic [15:0] preset_speed [8];

  logic [15:0] wd;
  assign wd = reg_wdata_i;

  // Writes outside a field's range are clamped, not rejected; system_max_speed is stored as written
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      limit_source_select       <= TQSL_SRC_DEF[1:0];
      basic_speed_ceiling       <= TQSL_CEIL_DEF;
      overspeed_feedback_margin <= TQSL_MARGIN_DEF;
      system_max_speed          <= TQSL_SYS_MAX_DEF;
      speed_gain_set_a          <= TQSL_SPD_GAIN_DEF;
      speed_gain_set_b          <= TQSL_SPD_GAIN_DEF;
      speed_integ_time_set_a    <= TQSL_INTEG_A_DEF;
      speed_integ_time_set_b    <= TQSL_INTEG_B_DEF;
      position_gain_set_a       <= TQSL_POS_GAIN_DEF;
      position_gain_set_b       <= TQSL_POS_GAIN_DEF;
      inertia_ratio             <= TQSL_INERTIA_DEF;
      speed_ctrl_structure_coef <= TQSL_COEF_DEF;
    end else if (reg_wr_i) begin
      if (reg_addr_i == TQSL_OFS_LIMIT_SRC) begin
        limit_source_select <= 2'(clamp16(wd, 16'h0, TQSL_SRC_MAX));
      end else if (reg_addr_i == TQSL_OFS_BASIC_CEIL) begin
        basic_speed_ceiling <= clamp16(wd, TQSL_CEIL_MIN, TQSL_CEIL_MAX);
      end else if (reg_addr_i == TQSL_OFS_FB_MARGIN) begin
        overspeed_feedback_margin <=
          clamp16(wd, TQSL_MARGIN_MIN, TQSL_MARGIN_MAX);
      end else if (reg_addr_i == TQSL_OFS_SYS_MAX) begin
        system_max_speed <= wd;
      end else if (reg_addr_i == TQSL_OFS_SPD_GAIN_A) begin
        speed_gain_set_a <= clamp16(wd, TQSL_SPD_GAIN_MIN, TQSL_SPD_GAIN_MAX);
      end else if (reg_addr_i == TQSL_OFS_SPD_GAIN_B) begin
        speed_gain_set_b <= clamp16(wd, TQSL_SPD_GAIN_MIN, TQSL_SPD_GAIN_MAX);
      end else if (reg_addr_i == TQSL_OFS_INTEG_A) begin
        speed_integ_time_set_a <= clamp16(wd, TQSL_INTEG_MIN, TQSL_INTEG_MAX);
      end else if (reg_addr_i == TQSL_OFS_INTEG_B) begin
        speed_integ_time_set_b <= clamp16(wd, TQSL_INTEG_MIN, TQSL_INTEG_MAX);
      end else if (reg_addr_i == TQSL_OFS_POS_GAIN_A) begin
        position_gain_set_a <=
          clamp16(wd, TQSL_POS_GAIN_MIN, TQSL_POS_GAIN_MAX);
      end else if (reg_addr_i == TQSL_OFS_POS_GAIN_B) begin
        position_gain_set_b <=
          clamp16(wd, TQSL_POS_GAIN_MIN, TQSL_POS_GAIN_MAX);
      end else if (reg_addr_i == TQSL_OFS_INERTIA) begin
        inertia_ratio <= clamp16(wd, TQSL_INERTIA_MIN, TQSL_INERTIA_MAX);
      end else if (reg_addr_i == TQSL_OFS_STRUCT_COEF) begin
        speed_ctrl_structure_coef <= clamp16(wd, 16'h0, TQSL_COEF_MAX);
      end
    end
  end

  // Preset speed table, eight words
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < 8; i++) begin
        preset_speed[i] <= TQSL_PRESET_DEF;
      end
    end else if (reg_wr_i && reg_addr_i[5:3] == TQSL_OFS_PRESET_BASE[5:3])
    begin
      preset_speed[reg_addr_i[2:0]] <= wd;
    end
  end

  // Update tick
  localparam int TW = $clog2(UPDATE_CYCLES + 1);
  logic [TW-1:0] tick_cnt;
  logic          tick;
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == TW'(UPDATE_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // Sampled operands; preset magnitude since ceilings ignore sign
  logic [15:0] speed_mag;
  logic [15:0] analog_mag;
  logic [15:0] preset_mag;
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      speed_mag  <= 16'h0;
      analog_mag <= 16'h0;
      preset_mag <= 16'h0;
    end else begin
      speed_mag  <= mag16(motor_speed_i);
      analog_mag <= mag16(analog_speed_cmd_i);
      preset_mag <= mag16(preset_speed[preset_idx]);
    end
  end

  tqsl_limit_s calc;
  tqsl_limit_calc u_calc (
    .src_i       (limit_source_select),
    .basic_i     (basic_speed_ceiling),
    .analog_i    (analog_mag),
    .preset_i    (preset_mag),
    .sys_max_i   (system_max_speed),
    .margin_i    (overspeed_feedback_margin),
    .speed_mag_i (speed_mag),
    .result_o    (calc)
  );

  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      effective_ceiling_o <= TQSL_CEIL_DEF;
      overspeed_o         <= 1'b0;
      torque_scale_o      <= 16'hFFFF;
    end else if (tick) begin
      effective_ceiling_o <= calc.ceiling;
      overspeed_o         <= calc.over;
      torque_scale_o      <= calc.torque_scale;
    end
  end

  // Gain set and controller structure outputs
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      active_gains_o   <= '0;
      inertia_ratio_o  <= TQSL_INERTIA_DEF;
      pdff_coef_o      <= TQSL_COEF_DEF;
      ctrl_structure_o <= TQSL_CTRL_PI;
    end else begin
      if (pin_sync[3]) begin
        active_gains_o <= '{speed_integ_time_set_b == 16'h0 ? 16'h0 :
                            speed_gain_set_b, speed_integ_time_set_b,
                            position_gain_set_b};
      end else begin
        active_gains_o <= '{speed_gain_set_a, speed_integ_time_set_a,
                            position_gain_set_a};
      end
      inertia_ratio_o <= inertia_ratio;
      pdff_coef_o     <= speed_ctrl_structure_coef;
      if (speed_ctrl_structure_coef == 16'h0) begin
        ctrl_structure_o <= TQSL_CTRL_IP;
      end else if (speed_ctrl_structure_coef == TQSL_COEF_MAX) begin
        ctrl_structure_o <= TQSL_CTRL_PI;
      end else begin
        ctrl_structure_o <= TQSL_CTRL_PDFF;
      end
    end
  end

  // Register read, data in the following cycle; unmapped reads zero
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata_o <= 16'h0;
    end else if (reg_rd_i) begin
      if (reg_addr_i == TQSL_OFS_LIMIT_SRC) begin
        reg_rdata_o <= {14'h0, limit_source_select};
      end else if (reg_addr_i == TQSL_OFS_BASIC_CEIL) begin
        reg_rdata_o <= basic_speed_ceiling;
      end else if (reg_addr_i == TQSL_OFS_FB_MARGIN) begin
        reg_rdata_o <= overspeed_feedback_margin;
      end else if (reg_addr_i == TQSL_OFS_SYS_MAX) begin
        reg_rdata_o <= system_max_speed;
      end else if (reg_addr_i == TQSL_OFS_SPD_GAIN_A) begin
        reg_rdata_o <= speed_gain_set_a;
      end else if (reg_addr_i == TQSL_OFS_SPD_GAIN_B) begin
        reg_rdata_o <= speed_gain_set_b;
      end else if (reg_addr_i == TQSL_OFS_INTEG_A) begin
        reg_rdata_o <= speed_integ_time_set_a;
      end else if (reg_addr_i == TQSL_OFS_INTEG_B) begin
        reg_rdata_o <= speed_integ_time_set_b;
      end else if (reg_addr_i == TQSL_OFS_POS_GAIN_A) begin
        reg_rdata_o <= position_gain_set_a;
      end else if (reg_addr_i == TQSL_OFS_POS_GAIN_B) begin
        reg_rdata_o <= position_gain_set_b;
      end else if (reg_addr_i == TQSL_OFS_INERTIA) begin
        reg_rdata_o <= inertia_ratio;
      end else if (reg_addr_i == TQSL_OFS_STRUCT_COEF) begin
        reg_rdata_o <= speed_ctrl_structure_coef;
      end else if (reg_addr_i == TQSL_OFS_EFF_CEIL) begin
        reg_rdata_o <= effective_ceiling_o;
      end else if (reg_addr_i == TQSL_OFS_STATUS) begin
        reg_rdata_o <= {12'h0, preset_idx, overspeed_o};
      end else if (reg_addr_i[5:3] == TQSL_OFS_PRESET_BASE[5:3]) begin
        reg_rdata_o <= preset_speed[reg_addr_i[2:0]];
      end else begin
        reg_rdata_o <= 16'h0;
      end
    end else begin
      reg_rdata_o <= 16'h0;
    end
  end
endmodule

// ===== rtl/tqsl_pkg.sv
// Package for the torque-mode speed limiter: register map, defaults, types.
// Assumes a single 200 MHz clock and a plain strobe register port.
package tqsl_pkg;

  localparam int TQSL_AW = 6;
  localparam int TQSL_DW = 16;

  // Register word offsets
  localparam logic [5:0] TQSL_OFS_LIMIT_SRC   = 6'h00;
  localparam logic [5:0] TQSL_OFS_BASIC_CEIL  = 6'h01;
  localparam logic [5:0] TQSL_OFS_FB_MARGIN   = 6'h02;
  localparam logic [5:0] TQSL_OFS_SYS_MAX     = 6'h03;
  localparam logic [5:0] TQSL_OFS_SPD_GAIN_A  = 6'h04;
  localparam logic [5:0] TQSL_OFS_SPD_GAIN_B  = 6'h05;
  localparam logic [5:0] TQSL_OFS_INTEG_A     = 6'h06;
  localparam logic [5:0] TQSL_OFS_INTEG_B     = 6'h07;
  localparam logic [5:0] TQSL_OFS_POS_GAIN_A  = 6'h08;
  localparam logic [5:0] TQSL_OFS_POS_GAIN_B  = 6'h09;
  localparam logic [5:0] TQSL_OFS_INERTIA     = 6'h0A;
  localparam logic [5:0] TQSL_OFS_STRUCT_COEF = 6'h0B;
  localparam logic [5:0] TQSL_OFS_EFF_CEIL    = 6'h0C;
  localparam logic [5:0] TQSL_OFS_STATUS      = 6'h0D;
  localparam logic [5:0] TQSL_OFS_PRESET_BASE = 6'h10;

  // Ranges and defaults; tenth-unit values are scaled by ten
  localparam logic [15:0] TQSL_SRC_MAX       = 16'h0002;
  localparam logic [15:0] TQSL_SRC_DEF       = 16'h0000;
  localparam logic [15:0] TQSL_CEIL_MIN      = 16'h0000;
  localparam logic [15:0] TQSL_CEIL_MAX      = 16'h1388; // 5000
  localparam logic [15:0] TQSL_CEIL_DEF      = 16'h0BB8; // 3000
  localparam logic [15:0] TQSL_MARGIN_MIN    = 16'h0001;
  localparam logic [15:0] TQSL_MARGIN_MAX    = 16'h1388;
  localparam logic [15:0] TQSL_MARGIN_DEF    = 16'h005A; // 90
  localparam logic [15:0] TQSL_SYS_MAX_DEF   = 16'h1388;
  localparam logic [15:0] TQSL_SPD_GAIN_MIN  = 16'h0001;
  localparam logic [15:0] TQSL_SPD_GAIN_MAX  = 16'h0BB8; // 3000
  localparam logic [15:0] TQSL_SPD_GAIN_DEF  = 16'h0028; // 40
  localparam logic [15:0] TQSL_INTEG_MIN     = 16'h000A; // 1.0
  localparam logic [15:0] TQSL_INTEG_MAX     = 16'h2710; // 1000.0
  localparam logic [15:0] TQSL_INTEG_A_DEF   = 16'h00C8; // 20.0
  localparam logic [15:0] TQSL_INTEG_B_DEF   = 16'h0064; // 10.0
  localparam logic [15:0] TQSL_POS_GAIN_MIN  = 16'h0001;
  localparam logic [15:0] TQSL_POS_GAIN_MAX  = 16'h03E8; // 1000
  localparam logic [15:0] TQSL_POS_GAIN_DEF  = 16'h0028;
  localparam logic [15:0] TQSL_INERTIA_MIN   = 16'h0000;
  localparam logic [15:0] TQSL_INERTIA_MAX   = 16'h07D0; // 200.0
  localparam logic [15:0] TQSL_INERTIA_DEF   = 16'h000A; // 1.0
  localparam logic [15:0] TQSL_COEF_MAX      = 16'h0064; // 100
  localparam logic [15:0] TQSL_COEF_DEF      = 16'h0064;
  localparam logic [15:0] TQSL_PRESET_DEF    = 16'h0000;

  // Control update period
  localparam int TQSL_UPDATE_NS     = 10000;
  localparam int TQSL_CLK_NS        = 5;
  localparam int TQSL_UPDATE_CYCLES = TQSL_UPDATE_NS / TQSL_CLK_NS;

  typedef enum logic [1:0] {
    TQSL_SRC_BASIC,
    TQSL_SRC_ANALOG,
    TQSL_SRC_PRESET
  } tqsl_src_e;

  typedef enum logic [1:0] {
    TQSL_CTRL_IP,
    TQSL_CTRL_PDFF,
    TQSL_CTRL_PI
  } tqsl_ctrl_e;

  typedef struct packed {
    logic [15:0] speed_gain;
    logic [15:0] integ_time;
    logic [15:0] position_gain;
  } tqsl_gain_set_s;

  typedef struct packed {
    logic [15:0] ceiling;
    logic        over;
    logic [15:0] torque_scale;
  } tqsl_limit_s;

endpackage

// ===== rtl/tqsl_limit_calc.sv
// Combinational ceiling selection and overspeed feedback scaling.
// Assumes registered inputs from the same clock domain.
`timescale 1ns/1ps
module tqsl_limit_calc (
  input  wire logic [1:0]  src_i,
  input  wire logic [15:0] basic_i,
  input  wire logic [15:0] analog_i,
  input  wire logic [15:0] preset_i,
  input  wire logic [15:0] sys_max_i,
  input  wire logic [15:0] margin_i,
  input  wire logic [15:0] speed_mag_i,
  output tqsl_pkg::tqsl_limit_s result_o
);
  import tqsl_pkg::*;

  function automatic logic [15:0] min16(input logic [15:0] a,
                                        input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction

  logic [15:0] ceil;
  logic [16:0] excess;
  logic [31:0] num;
  logic [15:0] quot;

  always_comb begin
    ceil = basic_i;
    if (src_i == 2'(TQSL_SRC_ANALOG)) begin
      ceil = min16(basic_i, analog_i);
    end else if (src_i == 2'(TQSL_SRC_PRESET)) begin
      ceil = min16(basic_i, preset_i);
    end
    ceil = min16(ceil, sys_max_i);
  end

  // Linear falloff: full torque at the ceiling, zero one margin above it
  always_comb begin
    excess = {1'b0, speed_mag_i} - {1'b0, ceil};
    num    = 32'h0;
    quot   = 16'hFFFF;
    result_o.ceiling = ceil;
    result_o.over    = speed_mag_i > ceil;
    if (result_o.over) begin
      if (excess[15:0] >= margin_i) begin
        quot = 16'h0000;
      end else begin
        num  = {16'h0, margin_i - excess[15:0]} << 16;
        quot = 16'((num - 32'h1) / {16'h0, margin_i});
      end
    end
    result_o.torque_scale = quot;
  end
endmodule

// ===== bench/tqsl_assertions.sv
// Checker for the torque-mode speed limiter, watching top-level ports only.
// Assumes one clock domain and the package register offsets.
`timescale 1ns/1ps
module tqsl_checker #(
  parameter int UPDATE_CYCLES = tqsl_pkg::TQSL_UPDATE_CYCLES
) (
  input wire logic                         ref_clk_i,
  input wire logic                         rst_n_i,
  input wire logic [tqsl_pkg::TQSL_AW-1:0] reg_addr_i,
  input wire logic                         reg_rd_i,
  input wire logic [tqsl_pkg::TQSL_DW-1:0] reg_rdata_o,
  input wire logic [15:0]                  effective_ceiling_o,
  input wire logic                         overspeed_o,
  input wire logic [15:0]                  torque_scale_o,
  input wire tqsl_pkg::tqsl_gain_set_s     active_gains_o,
  input wire logic [15:0]                  inertia_ratio_o,
  input wire logic [15:0]                  pdff_coef_o,
  input wire tqsl_pkg::tqsl_ctrl_e         ctrl_structure_o
);
  import tqsl_pkg::*;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Cycles since the ceiling last moved; saturates so reset looks settled
  int since;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      since <= UPDATE_CYCLES;
    end else if ($changed(effective_ceiling_o)) begin
      since <= 1;
    end else if (since < UPDATE_CYCLES) begin
      since <= since + 1;
    end
  end

  sequence s_ceil_read;
    reg_rd_i && reg_addr_i == TQSL_OFS_EFF_CEIL;
  endsequence

  property p_struct_map;
    $stable(pdff_coef_o) |->
      ctrl_structure_o == ((pdff_coef_o == 16'h0000) ? TQSL_CTRL_IP :
                           (pdff_coef_o == 16'h0064) ? TQSL_CTRL_PI :
                           TQSL_CTRL_PDFF);
  endproperty

  chk_ceil_bound: assert property (
    effective_ceiling_o <= TQSL_CEIL_MAX)
    else $error("ceiling above the top speed");
  chk_scale_full: assert property (
    !overspeed_o |-> torque_scale_o == 16'hFFFF)
    else $error("torque cut without overspeed");
  chk_scale_cut: assert property (
    overspeed_o |-> torque_scale_o < 16'hFFFF)
    else $error("overspeed without torque cut");
  chk_tick_spacing: assert property (
    $changed(effective_ceiling_o) |-> since >= UPDATE_CYCLES)
    else $error("ceiling moved between update ticks");
  chk_read_ceil: assert property (
    s_ceil_read |=> reg_rdata_o == $past(effective_ceiling_o))
    else $error("ceiling readback differs from output");
  chk_struct_map: assert property (p_struct_map)
    else $error("controller structure does not match coefficient");
  chk_coef_range: assert property (pdff_coef_o <= TQSL_COEF_MAX)
    else $error("coefficient above 100");
  chk_inertia_range: assert property (
    inertia_ratio_o <= TQSL_INERTIA_MAX)
    else $error("inertia ratio above 200.0");
  chk_gain_range: assert property (
    active_gains_o.speed_gain <= TQSL_SPD_GAIN_MAX &&
    active_gains_o.integ_time <= TQSL_INTEG_MAX &&
    active_gains_o.position_gain <= TQSL_POS_GAIN_MAX)
    else $error("active gain above its range");
endmodule

bind tqsl_top tqsl_checker #(.UPDATE_CYCLES(UPDATE_CYCLES)) i_tqsl_checker (
  .ref_clk_i           (ref_clk_i),
  .rst_n_i             (rst_n_i),
  .reg_addr_i          (reg_addr_i),
  .reg_rd_i            (reg_rd_i),
  .reg_rdata_o         (reg_rdata_o),
  .effective_ceiling_o (effective_ceiling_o),
  .overspeed_o         (overspeed_o),
  .torque_scale_o      (torque_scale_o),
  .active_gains_o      (active_gains_o),
  .inertia_ratio_o     (inertia_ratio_o),
  .pdff_coef_o         (pdff_coef_o),
  .ctrl_structure_o    (ctrl_structure_o)
);

// ===== bench/tqsl_motor_model.sv
// Motor with encoder feedback: reports its speed every cycle.
// Assumes the bench sets a target speed and picks prompt or ramped motion.
`timescale 1ns/1ps
module tqsl_motor_model (
  input  wire logic               ref_clk_i,
  input  wire logic               slow_i,
  input  wire logic signed [15:0] target_i,
  input  wire logic [15:0]        torque_scale_i,
  output logic signed [15:0]      speed_o
);
  initial speed_o = 16'sh0000;

  // Ramped mode cannot step speed upward once torque is fully removed
  always @(posedge ref_clk_i) begin
    if (!slow_i) begin
      speed_o <= target_i;
    end else if (speed_o < target_i && torque_scale_i != 16'h0000) begin
      speed_o <= speed_o + 16'sh0001;
    end else if (speed_o > target_i) begin
      speed_o <= speed_o - 16'sh0001;
    end
  end
endmodule

// ===== bench/tb_tqsl_top.sv
// Self-checking bench for the torque-mode speed limiter.
// Assumes the motor model and checker are compiled before this file.
`timescale 1ns/1ps
module tb_tqsl_top;
  import tqsl_pkg::*;
  localparam int UPD = 8;
  localparam logic [15:0] DEF_V [14] = '{16'h0000, 16'h0BB8, 16'h005A,
    16'h1388, 16'h0028, 16'h0028, 16'h00C8, 16'h0064, 16'h0028, 16'h0028,
    16'h000A, 16'h0064, 16'h0BB8, 16'h0000};
  localparam logic [5:0] CL_A [12] = '{6'h01, 6'h02, 6'h02, 6'h00, 6'h04,
    6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B};
  localparam logic [15:0] CL_W [12] = '{16'hFFFF, 16'h0000, 16'hFFFF,
    16'h0007, 16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF,
    16'hFFFF, 16'hFFFF};
  localparam logic [15:0] CL_E [12] = '{16'h1388, 16'h0001, 16'h1388,
    16'h0002, 16'h0001, 16'h0BB8, 16'h000A, 16'h2710, 16'h0001, 16'h03E8,
    16'h07D0, 16'h0064};
  typedef struct {
    logic [5:0]  addr;
    logic [15:0] exp;
  } tqsl_note_s;

  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [5:0]         addr = 6'h00;
  logic [15:0]        wdata = 16'h0000;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic [15:0]        rdata;
  logic [2:0]         sel = 3'h0;
  logic signed [15:0] analog = 16'sh0000;
  logic signed [15:0] target = 16'sh0000;
  logic signed [15:0] speed;
  logic               slow = 1'b0;
  logic               gsel = 1'b0;
  logic [15:0]        eff;
  logic               over;
  logic [15:0]        scale;
  tqsl_gain_set_s     gains;
  logic [15:0]        inertia;
  logic [15:0]        coef;
  tqsl_ctrl_e         ctrl;
  tqsl_note_s         exp_q[$];
  tqsl_note_s         note;
  logic               rd_seen = 1'b0;
  int                 err_total = 0;
  int                 num_checks = 0;
  logic [31:0]        seed = 32'h05420E13;

  tqsl_top #(.UPDATE_CYCLES(UPD)) i_tqsl_top (
    .ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .preset_speed_sel_bit0_i(sel[0]), .preset_speed_sel_bit1_i(sel[1]),
    .preset_speed_sel_bit2_i(sel[2]), .analog_speed_cmd_i(analog),
    .motor_speed_i(speed), .gain_set_sel_i(gsel),
    .effective_ceiling_o(eff), .overspeed_o(over), .torque_scale_o(scale),
    .active_gains_o(gains), .inertia_ratio_o(inertia),
    .pdff_coef_o(coef), .ctrl_structure_o(ctrl));

  tqsl_motor_model i_tqsl_motor_model (.ref_clk_i(clk), .slow_i(slow),
    .target_i(target), .torque_scale_i(scale), .speed_o(speed));

  initial begin
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic check(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    exp_q.push_back('{a, e});
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Tick period plus input registers and pin synchronisers
  task automatic settle();
    repeat (UPD + 8) @(posedge clk);
  endtask

  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen === 1'b1) begin
      note = exp_q.pop_front();
      check($sformatf("reg %h", note.addr), {32'h0, rdata},
            {32'h0, note.exp});
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  initial begin
    logic signed [15:0] spd;
    int i, m, mag, e, k;
    logic [15:0] esc;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wr_reg(6'h0C, 16'h1234);
    wr_reg(6'h3F, 16'h1234);
    for (i = 0; i < 14; i++) begin
      rd_reg(6'(i), DEF_V[i]);
    end
    rd_reg(6'h10, 16'h0000);
    rd_reg(6'h3F, 16'h0000);
    for (i = 0; i < 12; i++) begin
      wr_reg(CL_A[i], CL_W[i]);
      rd_reg(CL_A[i], CL_E[i]);
    end
    wr_reg(6'h02, 16'h005A);
    wr_reg(6'h00, 16'h0000);
    wr_reg(6'h01, 16'h07D0);
    analog <= -16'sd500;
    settle();
    check("ceiling", {32'h0, eff}, 48'h07D0);
    rd_reg(6'h0C, 16'h07D0);
    wr_reg(6'h00, 16'h0001);
    settle();
    check("ceiling", {32'h0, eff}, 48'h01F4);
    analog <= 16'sd4000;
    settle();
    check("ceiling", {32'h0, eff}, 48'h07D0);
    wr_reg(6'h00, 16'h0000);
    wr_reg(6'h03, 16'h03E8);
    settle();
    check("ceiling", {32'h0, eff}, 48'h03E8);
    wr_reg(6'h03, 16'h1388);
    wr_reg(6'h00, 16'h0002);
    for (i = 0; i < 8; i++) begin
      spd = 16'(100 * (i + 1));
      wr_reg(6'(16 + i), i[0] ? -spd : spd);
    end
    for (i = 0; i < 8; i++) begin
      sel <= 3'(i);
      settle();
      check("ceiling", {32'h0, eff}, 48'(100 * (i + 1)));
      rd_reg(6'h0D, {12'h000, 3'(i), 1'b0});
    end
    wr_reg(6'h00, 16'h0000);
    wr_reg(6'h01, 16'h03E8);
    for (i = 0; i < 10; i++) begin
      seed = xs(seed);
      m = 1 + int'(seed[7:0]);
      seed = xs(seed);
      spd = 16'sd900 + $signed({7'h00, seed[8:0]});
      if (i == 0) spd = 16'sd1000;
      if (seed[9]) spd = -spd;
      mag = int'(spd);
      if (mag < 0) mag = -mag;
      e = (mag > 1000) ? mag - 1000 : 0;
      esc = (e == 0) ? 16'hFFFF : (e >= m) ? 16'h0000 :
            16'(((m - e) * 65536 - 1) / m);
      wr_reg(6'h02, 16'(m));
      target <= spd;
      settle();
      check("overspeed", {47'h0, over}, {47'h0, e > 0});
      check("torque scale", {32'h0, scale}, {32'h0, esc});
      rd_reg(6'h0D, {12'h000, sel, e > 0});
    end
    wr_reg(6'h02, 16'h005A);
    target <= 16'sd0;
    settle();
    slow   <= 1'b1;
    target <= 16'sd3000;
    for (k = 0; k < 3000 && over !== 1'b1; k++) @(posedge clk);
    check("ramp reached", {47'h0, k < 3000}, 48'h1);
    repeat (2000) @(posedge clk);
    check("overspeed", {47'h0, over}, 48'h1);
    check("held speed",
          {47'h0, speed > 1000 && speed < 1110}, 48'h1);
    wr_reg(6'h04, 16'h0064);
    wr_reg(6'h06, 16'h00FA);
    wr_reg(6'h08, 16'h0032);
    wr_reg(6'h05, 16'h00C8);
    wr_reg(6'h07, 16'h01F4);
    wr_reg(6'h09, 16'h0019);
    repeat (6) @(posedge clk);
    check("gains a", gains, 48'h0064_00FA_0032);
    gsel <= 1'b1;
    repeat (6) @(posedge clk);
    check("gains b", gains, 48'h00C8_01F4_0019);
    for (i = 0; i < 4; i++) begin
      wr_reg(6'h0B, 16'((i == 3) ? 100 : i * 49));
      repeat (4) @(posedge clk);
      check("structure", {46'h0, ctrl},
            48'((i == 0) ? TQSL_CTRL_IP :
                (i == 3) ? TQSL_CTRL_PI : TQSL_CTRL_PDFF));
      check("coefficient", {32'h0, coef},
            48'((i == 3) ? 100 : i * 49));
    end
    wr_reg(6'h0A, 16'h0123);
    repeat (4) @(posedge clk);
    check("inertia", {32'h0, inertia}, 48'h0123);
    repeat (5) @(posedge clk);
    give_verdict();
  end
endmodule
